//--- hdl/sbc_ctrl.v
// stop method and dc braking sequencer, top level
`timescale 1ns/100ps
`include "sbc_regs.vh"
module sbc_ctrl #(
  parameter TICK_DIV = `SBC_CLK_HZ / `SBC_TICK_HZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  // control terminals (asynchronous pins)
  input wire run_cmd,
  input wire coast_stop_input,
  input wire ext_brake_input,
  // drive status from the same clock domain, 0.01 Hz units
  input wire [15:0] out_freq,
  input wire [15:0] freq_cmd,
  // to output stage
  output reg out_enable,
  output reg decel_stop,
  output reg dc_brake_on,
  output reg [7:0] dc_brake_current,
  output reg restart_req,
  output reg [1:0] restart_mode,
  // register read data
  output reg [15:0] rdata
);
  // ***************************************************
  // settings
  // ***************************************************
  reg [15:0] ctrl_reg; // stop, restart, select, trigger, duty
  reg [15:0] dc_brake_freq_reg; // brake frequency
  reg [15:0] dc_brake_delay_reg; // coast delay in ticks
  reg [15:0] dc_brake_force_reg; // force percent
  reg [15:0] dc_brake_hold_time_reg; // active time in ticks
  reg [15:0] carrier_freq_reg; // carrier in 0.1 kHz
  reg [7:0] func_sel_reg; // terminal function enables
  wire [1:0] stop_method_sel = ctrl_reg[`SBC_CTRL_STOP_LSB+1:`SBC_CTRL_STOP_LSB];
  wire [1:0] restart_after_coast_sel = ctrl_reg[`SBC_CTRL_RESTART_LSB+1:`SBC_CTRL_RESTART_LSB];
  wire [1:0] dc_brake_sel = ctrl_reg[`SBC_CTRL_BSEL_LSB+1:`SBC_CTRL_BSEL_LSB];
  wire [1:0] dc_brake_trigger_mode = ctrl_reg[`SBC_CTRL_TRIG_LSB+1:`SBC_CTRL_TRIG_LSB];
  wire light_duty_rating = ctrl_reg[`SBC_CTRL_LD_BIT];
  // func_sel bit 0 enables coast-stop terminal (032), bit 1 external brake (030)
  wire coast_fn_en = func_sel_reg[0];
  wire brake_fn_en = func_sel_reg[1];

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  reg [2:0] pin_s1_reg; // first stage, read only by second
  reg [2:0] pin_s2_reg; // second stage
  always @(posedge clk)
  begin
    if (rst)
    begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end
    else
    begin
      pin_s1_reg <= {ext_brake_input, coast_stop_input, run_cmd};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire run_s = pin_s2_reg[0];
  wire coast_s = pin_s2_reg[1] & coast_fn_en;
  // external brake ignored in frequency-command mode
  wire ext_s = pin_s2_reg[2] & brake_fn_en & (dc_brake_sel != `SBC_BSEL_FCMD);

  // ***************************************************
  // tick and force scaling
  // ***************************************************
  wire tick; // 0.01 s pulse
  wire [7:0] force_cur; // scaled and capped current
  sbc_tick #(.DIV(TICK_DIV)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );
  sbc_force u_force (
    .force_pct(dc_brake_force_reg[7:0]),
    .light_duty(light_duty_rating),
    .carrier(carrier_freq_reg),
    .current_pct(force_cur)
  );

  // ***************************************************
  // register writes
  // ***************************************************
  // out-of-range frequency, delay, force and hold values are clamped to the documented maximum
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg <= `SBC_CTRL_RST;
      dc_brake_freq_reg <= `SBC_FREQ_RST;
      dc_brake_delay_reg <= `SBC_DELAY_RST;
      dc_brake_force_reg <= `SBC_FORCE_RST;
      dc_brake_hold_time_reg <= `SBC_HOLD_RST;
      carrier_freq_reg <= `SBC_CARR_RST;
      func_sel_reg <= `SBC_CMD_RST;
    end
    else if (wr)
    begin
      case (addr)
        `SBC_ADDR_CTRL: ctrl_reg <= {7'h00, wdata[8:0]};
        `SBC_ADDR_FREQ: dc_brake_freq_reg <= (wdata > `SBC_FREQ_MAX) ? `SBC_FREQ_MAX : wdata;
        `SBC_ADDR_DELAY: dc_brake_delay_reg <= (wdata > `SBC_DELAY_MAX) ? `SBC_DELAY_MAX : wdata;
        `SBC_ADDR_FORCE:
          dc_brake_force_reg <= (wdata > 16'h0064) ? 16'h0064 : wdata;
        `SBC_ADDR_HOLD: dc_brake_hold_time_reg <= (wdata > `SBC_HOLD_MAX) ? `SBC_HOLD_MAX : wdata;
        `SBC_ADDR_CARR: carrier_freq_reg <= wdata;
        `SBC_ADDR_CMD: func_sel_reg <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // ***************************************************
  // sequencer
  // ***************************************************
  localparam ST_RUN = 5'b00001; // driving, output on
  localparam ST_DECEL = 5'b00010; // decelerating stop
  localparam ST_DELAY = 5'b00100; // coasting before braking
  localparam ST_BRAKE = 5'b01000; // dc braking
  localparam ST_IDLE = 5'b10000; // stopped, output off

  reg [4:0] state_reg; // current state
  reg [4:0] state_next;
  reg [15:0] tmr_reg; // tick counter for delay and hold
  reg tmr_clr; // restart timer from zero
  reg coasted_reg; // last stop was a coast
  reg coasted_next;
  reg ext_src_reg; // braking was started by the external input
  reg ext_src_next;
  reg ext_d_reg; // external input one cycle ago, for edge
  wire ext_rise = ext_s & ~ext_d_reg;
  // stop braking condition
  wire below_f = out_freq <= dc_brake_freq_reg;
  wire int_stop_en = (dc_brake_sel == `SBC_BSEL_ON);
  // frequency-command braking: both below, release at freq plus 2 Hz
  wire fcmd_mode = (dc_brake_sel == `SBC_BSEL_FCMD);
  wire fcmd_hit = fcmd_mode & (freq_cmd < dc_brake_freq_reg) & (out_freq < dc_brake_freq_reg);
  wire fcmd_rel = freq_cmd >= dc_brake_freq_reg + `SBC_HYST_2HZ;
  wire level = (dc_brake_trigger_mode == `SBC_TRIG_LEVEL);

  // next state; coast-stop input overrides everything
  always @*
  begin
    state_next = state_reg;
    coasted_next = coasted_reg;
    ext_src_next = ext_src_reg;
    tmr_clr = 1'b0;
    case (state_reg)
      ST_RUN:
      begin
        if (ext_rise)
        begin
          state_next = ST_DELAY; // external brake during run waits the delay
          ext_src_next = 1'b1;
          tmr_clr = 1'b1;
        end
        else if (fcmd_hit && run_s)
        begin
          state_next = ST_DELAY;
          ext_src_next = 1'b0;
          tmr_clr = 1'b1;
        end
        else if (!run_s)
        begin
          if (stop_method_sel == `SBC_STOP_COAST)
          begin
            state_next = ST_IDLE;
            coasted_next = 1'b1;
          end
          else
            state_next = ST_DECEL;
        end
      end
      ST_DECEL:
      begin
        if (ext_rise)
        begin
          state_next = ST_DELAY;
          ext_src_next = 1'b1;
          tmr_clr = 1'b1;
        end
        else if (run_s)
          state_next = ST_RUN;
        else if (int_stop_en && below_f)
        begin
          state_next = ST_DELAY;
          ext_src_next = 1'b0;
          tmr_clr = 1'b1;
        end
        else if (out_freq == 16'h0000)
          state_next = ST_IDLE;
      end
      ST_DELAY:
      begin
        if (tick && tmr_reg + 16'h0001 >= dc_brake_delay_reg || dc_brake_delay_reg == 16'h0000)
        begin
          state_next = ST_BRAKE;
          tmr_clr = 1'b1;
        end
        if (ext_src_reg && level && !ext_s)
          state_next = run_s ? ST_RUN : ST_IDLE;
      end
      ST_BRAKE:
      begin
        if (!level)
        begin
          if (tick && tmr_reg + 16'h0001 >= dc_brake_hold_time_reg)
            state_next = run_s && !ext_src_reg ? ST_RUN : ST_IDLE;
        end
        else if (ext_src_reg)
        begin
          if (!ext_s)
            state_next = run_s ? ST_RUN : ST_IDLE;
        end
        else if (fcmd_mode)
        begin
          if (fcmd_rel || !run_s)
            state_next = run_s ? ST_RUN : ST_IDLE;
        end
        else if (run_s)
          state_next = ST_RUN;
        if (!level && fcmd_mode && fcmd_rel && run_s)
          state_next = ST_RUN;
      end
      ST_IDLE:
      begin
        if (ext_rise)
        begin
          state_next = ST_BRAKE;
          ext_src_next = 1'b1;
          tmr_clr = 1'b1;
        end
        else if (run_s)
        begin
          if (fcmd_hit)
          begin
            state_next = ST_DELAY;
            ext_src_next = 1'b0;
            tmr_clr = 1'b1;
          end
          else
            state_next = ST_RUN;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // coast-stop input forces output off
    if (coast_s)
    begin
      state_next = ST_IDLE;
      coasted_next = 1'b1;
    end
  end

  // state, timer and edge registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      tmr_reg <= 16'h0000;
      coasted_reg <= 1'b0;
      ext_src_reg <= 1'b0;
      ext_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      coasted_reg <= coasted_next;
      ext_src_reg <= ext_src_next;
      ext_d_reg <= ext_s;
      if (tmr_clr)
        tmr_reg <= 16'h0000;
      else if (tick && tmr_reg != 16'hFFFF)
        tmr_reg <= tmr_reg + 16'h0001;
      // a start out of idle consumes the coasted mark
      if (state_reg == ST_IDLE && state_next == ST_RUN && !coast_s)
        coasted_reg <= 1'b0;
    end
  end

  // ***************************************************
  // outputs, all registered
  // ***************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      out_enable <= 1'b0;
      decel_stop <= 1'b0;
      dc_brake_on <= 1'b0;
      dc_brake_current <= 8'h00;
      restart_req <= 1'b0;
      restart_mode <= `SBC_RESTART_ZERO;
      rdata <= 16'h0000;
    end
    else
    begin
      // delay and idle keep the output off; the motor coasts
      out_enable <= (state_next == ST_RUN) | (state_next == ST_DECEL) | (state_next == ST_BRAKE);
      decel_stop <= (state_next == ST_DECEL);
      dc_brake_on <= (state_next == ST_BRAKE);
      dc_brake_current <= (state_next == ST_BRAKE) ? force_cur : 8'h00;
      // one-cycle pulse telling the output stage how to pick up a coasting motor
      restart_req <= (state_reg == ST_IDLE) && (state_next == ST_RUN) && coasted_reg;
      restart_mode <= restart_after_coast_sel;
      if (rd)
      begin
        case (addr)
          `SBC_ADDR_CTRL: rdata <= ctrl_reg;
          `SBC_ADDR_FREQ: rdata <= dc_brake_freq_reg;
          `SBC_ADDR_DELAY: rdata <= dc_brake_delay_reg;
          `SBC_ADDR_FORCE: rdata <= dc_brake_force_reg;
          `SBC_ADDR_HOLD: rdata <= dc_brake_hold_time_reg;
          `SBC_ADDR_CARR: rdata <= carrier_freq_reg;
          `SBC_ADDR_CMD: rdata <= {8'h00, func_sel_reg};
          `SBC_ADDR_STAT: rdata <= {coasted_reg, ext_src_reg, 1'b0, force_cur, state_reg};
          default: rdata <= 16'h0000;
        endcase
      end
      else
        rdata <= 16'h0000;
    end
  end
endmodule // sbc_ctrl

//--- hdl/sbc_regs.vh
// register offsets, field codes, reset values and timing counts for the stop/brake sequencer
`ifndef SBC_REGS_VH
`define SBC_REGS_VH
// register indices (word addresses on the plain port)
`define SBC_ADDR_CTRL 4'h0
`define SBC_ADDR_FREQ 4'h1
`define SBC_ADDR_DELAY 4'h2
`define SBC_ADDR_FORCE 4'h3
`define SBC_ADDR_HOLD 4'h4
`define SBC_ADDR_CARR 4'h5
`define SBC_ADDR_CMD 4'h6
`define SBC_ADDR_STAT 4'h7
// control register fields
`define SBC_CTRL_STOP_LSB 0
`define SBC_CTRL_RESTART_LSB 2
`define SBC_CTRL_BSEL_LSB 4
`define SBC_CTRL_TRIG_LSB 6
`define SBC_CTRL_LD_BIT 8
// codes
`define SBC_STOP_DECEL 2'h0
`define SBC_STOP_COAST 2'h1
`define SBC_RESTART_ZERO 2'h0
`define SBC_BSEL_OFF 2'h0
`define SBC_BSEL_ON 2'h1
`define SBC_BSEL_FCMD 2'h2
`define SBC_TRIG_EDGE 2'h0
`define SBC_TRIG_LEVEL 2'h1
// reset values (frequency in 0.01 Hz, times in 0.01 s ticks, force in %)
`define SBC_CTRL_RST 16'h0000
`define SBC_FREQ_RST 16'h0032
`define SBC_DELAY_RST 16'h0000
`define SBC_FORCE_RST 16'h0032
`define SBC_HOLD_RST 16'h0032
`define SBC_CARR_RST 16'h0014
`define SBC_CMD_RST 8'h03
// limits
`define SBC_FREQ_MAX 16'hE678
`define SBC_DELAY_MAX 16'h01F4
`define SBC_HOLD_MAX 16'h1770
`define SBC_FORCE_MAX 8'h64
`define SBC_HYST_2HZ 16'h00C8
`define SBC_CARR_2KHZ 16'h0014
`define SBC_LD_SCALE 8'h46
// timing
`define SBC_CLK_HZ 50000000
`define SBC_TICK_HZ 100
`endif

//--- hdl/sbc_tick.v
// divider giving one pulse every 0.01 s of the controller clock
`timescale 1ns/100ps
`include "sbc_regs.vh"
module sbc_tick #(
  parameter DIV = `SBC_CLK_HZ / `SBC_TICK_HZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // tick out
  output reg tick
);
  reg [23:0] cnt_reg; // cycles into the current tick

  // free running counter; the tick is a one-cycle pulse
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 24'h000000;
      tick <= 1'b0;
    end
    else if (cnt_reg >= DIV[23:0] - 24'h000001)
    begin
      cnt_reg <= 24'h000000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 24'h000001;
      tick <= 1'b0;
    end
  end
endmodule // sbc_tick

//--- hdl/sbc_force.v
// braking current scaling: duty rating and carrier frequency limit
`timescale 1ns/100ps
`include "sbc_regs.vh"
module sbc_force (
  // settings
  input wire [7:0] force_pct,
  input wire light_duty,
  input wire [15:0] carrier,
  // result, in percent of rated output current
  output reg [7:0] current_pct
);
  reg [15:0] scaled; // force after duty scaling
  reg [7:0] cap; // carrier limit
  reg [15:0] cap_wide; // carrier limit before narrowing to percent

  // light duty: 100 % setting gives 70 % of rated current; above 2 kHz the force is capped
  always @*
  begin
    cap_wide = 16'h0000;
    if (light_duty)
      scaled = ({8'h00, force_pct} * {8'h00, `SBC_LD_SCALE}) / 16'h0064;
    else
      scaled = {8'h00, force_pct};
    // cap falls 1 % per 0.1 kHz over 2 kHz, floor at 20 %; a linear stand-in curve
    if (carrier > `SBC_CARR_2KHZ)
    begin
      if (carrier - `SBC_CARR_2KHZ >= 16'h0050)
        cap = 8'h14;
      else
      begin
        // stays within 20..98 here, so the upper byte is always zero
        cap_wide = 16'h0063 - carrier + `SBC_CARR_2KHZ;
        cap = cap_wide[7:0];
      end
    end
    else
      cap = `SBC_FORCE_MAX;
    if (scaled[7:0] > cap)
      current_pct = cap;
    else
      current_pct = scaled[7:0];
  end
endmodule // sbc_force

//--- tb/sbc_ctrl_properties.sv
// concurrent checks on the stop and dc brake sequencer ports
`timescale 1ns/100ps
module sbc_ctrl_properties #(
  parameter TICK_DIV = 10
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  // terminals and drive status
  input wire run_cmd,
  input wire coast_stop_input,
  input wire ext_brake_input,
  input wire [15:0] out_freq,
  input wire [15:0] freq_cmd,
  // outputs under watch
  input wire out_enable,
  input wire decel_stop,
  input wire dc_brake_on,
  input wire [7:0] dc_brake_current,
  input wire restart_req,
  input wire [1:0] restart_mode,
  input wire [15:0] rdata
);
  // ****
  // shadow state
  // ****
  reg [15:0] ctrl_reg; // copy of the control word
  reg [15:0] hold_reg; // copy of the hold time, clamped as the block does
  reg [31:0] brk_len; // cycles of the current braking spell
  wire ctl_wr = wr && addr == 4'h0; // control word write
  // one tick of slack: the tick divider runs free of the trigger
  wire [31:0] brk_lim = (hold_reg + 32'd1) * TICK_DIV + 32'd4;
  // shadows follow the writes the block takes
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg <= 16'h0000;
      hold_reg <= 16'h0032;
      brk_len <= 32'h0;
    end
    else
    begin
      if (ctl_wr)
        ctrl_reg <= wdata;
      if (wr && addr == 4'h4)
        hold_reg <= (wdata > 16'h1770) ? 16'h1770 : wdata;
      brk_len <= dc_brake_on ? brk_len + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // properties
  // ****
  property p_decel;
    $fell(run_cmd) && ctrl_reg[5:0] == 6'h00 && out_enable && out_freq != 16'h0
      |-> ##[1:6] decel_stop;
  endproperty
  a_decel: assert property (p_decel) else $error("no decelerating stop");
  property p_coast;
    $fell(run_cmd) && ctrl_reg[1:0] == 2'h1 |-> ##[1:6] !out_enable;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop kept output");
  property p_restart_pulse;
    restart_req |=> !restart_req;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("long restart pulse");
  property p_restart_mode;
    ctl_wr ##1 (!ctl_wr)[*3] |-> restart_mode == ctrl_reg[3:2];
  endproperty
  a_restart_mode: assert property (p_restart_mode) else $error("restart mode stale");
  property p_coast_in;
    coast_stop_input[*8] |-> !out_enable && !dc_brake_on;
  endproperty
  a_coast_in: assert property (p_coast_in) else $error("coast input ignored");
  property p_current;
    dc_brake_current <= 8'h64 && (dc_brake_on || dc_brake_current == 8'h00);
  endproperty
  a_current: assert property (p_current) else $error("bad brake current");
  property p_edge_len;
    dc_brake_on && ctrl_reg[7:6] == 2'h0 |-> brk_len <= brk_lim;
  endproperty
  a_edge_len: assert property (p_edge_len) else $error("edge braking too long");
  sequence s_ext_stopped;
    (!out_enable && !decel_stop && !run_cmd && !coast_stop_input && ext_brake_input
      && ctrl_reg[7:4] == 4'h5)[*8];
  endsequence
  property p_ext_now;
    s_ext_stopped |-> dc_brake_on;
  endproperty
  a_ext_now: assert property (p_ext_now) else $error("external brake delayed");
  c_brake: cover property ($rose(dc_brake_on));
  c_restart: cover property (restart_req);
  c_decel: cover property ($rose(decel_stop));
endmodule // sbc_ctrl_properties
bind sbc_ctrl sbc_ctrl_properties #(.TICK_DIV(TICK_DIV)) i_props (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .run_cmd(run_cmd), .coast_stop_input(coast_stop_input),
  .ext_brake_input(ext_brake_input), .out_freq(out_freq), .freq_cmd(freq_cmd),
  .out_enable(out_enable), .decel_stop(decel_stop), .dc_brake_on(dc_brake_on),
  .dc_brake_current(dc_brake_current), .restart_req(restart_req),
  .restart_mode(restart_mode), .rdata(rdata));

//--- tb/sbc_drive_model.sv
// behavioural output stage reporting the output frequency
`timescale 1ns/100ps
module sbc_drive_model (
  // clock and reset
  input wire clk,
  input wire rst,
  // enable and decelerate from the sequencer, frequency command from the bench
  input wire out_enable,
  input wire decel_stop,
  input wire [15:0] freq_cmd,
  // reported output frequency, 0.01 Hz
  output reg [15:0] out_freq
);
  localparam [15:0] STEP = 16'h0010; // steep slope keeps runs short
  // ramp toward the command, down while decelerating, zero when shut off
  always @(posedge clk)
  begin
    if (rst || !out_enable)
      out_freq <= 16'h0000;
    else if (decel_stop)
      out_freq <= (out_freq > STEP) ? out_freq - STEP : 16'h0000;
    else if (out_freq + STEP <= freq_cmd)
      out_freq <= out_freq + STEP;
    else if (out_freq > freq_cmd + STEP)
      out_freq <= out_freq - STEP;
    else
      out_freq <= freq_cmd;
  end
endmodule // sbc_drive_model

//--- tb/tb_stop_and_dc_brake_control.sv
// self-checking bench for the stop and dc brake sequencer
`timescale 1ns/100ps
`include "sbc_regs.vh"
module tb_stop_and_dc_brake_control;
  // ****
  // stimulus and expectations
  // ****
  localparam int TD = 10; // shortened divider: one tick is ten cycles
  localparam logic [15:0] RV [0:8] = '{`SBC_CTRL_RST, `SBC_FREQ_RST, `SBC_DELAY_RST,
    `SBC_FORCE_RST, `SBC_HOLD_RST, `SBC_CARR_RST, 16'h0003, 16'h0650, 16'h0000};
  localparam logic [15:0] MX [1:4] = '{16'hE678, 16'h01F4, 16'h0064, 16'h1770};
  // external brake cases: control word, carrier, expected current (0: none)
  localparam logic [15:0] EC [0:3] = '{16'h0150, 16'h0050, 16'h0040, 16'h0060};
  localparam logic [15:0] ECR [0:3] = '{16'h0014, 16'h001E, 16'h0014, 16'h0014};
  localparam logic [7:0] EI [0:3] = '{8'h46, 8'h59, 8'h64, 8'h00};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg run_cmd = 1'b0;
  reg coast_stop_input = 1'b0;
  reg ext_brake_input = 1'b0;
  reg [15:0] freq_cmd = 16'h0200;
  wire [15:0] out_freq;
  wire out_enable, decel_stop, dc_brake_on, restart_req;
  wire [7:0] dc_brake_current;
  wire [1:0] restart_mode;
  wire [15:0] rdata;
  int fails = 0;
  int n_tests = 0;
  int cnt;
  int i;
  int tcyc = 0;
  sbc_ctrl #(.TICK_DIV(TD)) i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .run_cmd(run_cmd), .coast_stop_input(coast_stop_input),
    .ext_brake_input(ext_brake_input), .out_freq(out_freq), .freq_cmd(freq_cmd),
    .out_enable(out_enable), .decel_stop(decel_stop), .dc_brake_on(dc_brake_on),
    .dc_brake_current(dc_brake_current), .restart_req(restart_req),
    .restart_mode(restart_mode), .rdata(rdata));
  sbc_drive_model i_model (.clk(clk), .rst(rst), .out_enable(out_enable),
    .decel_stop(decel_stop), .freq_cmd(freq_cmd), .out_freq(out_freq));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 ck(rdata, e);
  endtask
  task automatic nclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic sg(input int s);
    case (s)
      0: sg = out_enable;
      1: sg = dc_brake_on;
      2: sg = restart_req;
      default: sg = decel_stop;
    endcase
  endfunction
  // bounded wait for an output level; cnt keeps the cycles taken
  task automatic wt(input int s, input logic v, input int n);
    cnt = 0;
    while (sg(s) !== v && cnt < n)
    begin
      @(posedge clk);
      #1 cnt++;
    end
    ck({15'h0, sg(s)}, {15'h0, v});
  endtask
  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk)
  begin
    tcyc <= tcyc + 1;
    if (tcyc == 20000)
    begin
      fails++;
      $display("mismatch at %0t: run timed out", $time);
      tally_and_finish;
    end
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++)
      rchk(i[3:0], RV[i]);
    for (i = 1; i < 5; i++)
    begin
      wreg(i[3:0], 16'hFFFF);
      rchk(i[3:0], MX[i]);
    end
    // stop braking: 1 Hz, delay 2 ticks, hold 3 ticks, full force, edge
    wreg(4'h1, 16'h0064);
    wreg(4'h2, 16'h0002);
    wreg(4'h3, 16'h0064);
    wreg(4'h4, 16'h0003);
    wreg(4'h5, 16'h0014);
    wreg(4'h0, 16'h0010);
    run_cmd <= 1'b1;
    wt(0, 1'b1, 10);
    nclk(40);
    run_cmd <= 1'b0;
    wt(3, 1'b1, 8);
    wt(3, 1'b0, 100);
    wt(1, 1'b1, 4 * TD);
    ck({15'h0, cnt >= TD && cnt <= 2 * TD + 4}, 16'h0001);
    ck({8'h00, dc_brake_current}, 16'h0064);
    wt(1, 1'b0, 5 * TD);
    ck({15'h0, cnt >= 2 * TD && cnt <= 3 * TD + 4}, 16'h0001);
    // external brake while stopped, delay of 5 ticks to be skipped
    wreg(4'h2, 16'h0005);
    for (i = 0; i < 4; i++)
    begin
      wreg(4'h0, EC[i]);
      wreg(4'h5, ECR[i]);
      ext_brake_input <= 1'b1;
      nclk(8);
      ck({15'h0, dc_brake_on}, {15'h0, EI[i] != 8'h00});
      ck({8'h00, dc_brake_current}, {8'h00, EI[i]});
      nclk(60);
      ck({15'h0, dc_brake_on}, {15'h0, EI[i] != 8'h00});
      ext_brake_input <= 1'b0;
      wt(1, 1'b0, 8);
    end
    // coast stop with every restart code
    wreg(4'h2, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      wreg(4'h0, {12'h000, i[1:0], 2'h1});
      run_cmd <= 1'b1;
      wt(0, 1'b1, 10);
      nclk(5);
      run_cmd <= 1'b0;
      wt(0, 1'b0, 8);
      ck({15'h0, decel_stop}, 16'h0000);
      run_cmd <= 1'b1;
      wt(2, 1'b1, 10);
      ck({14'h0, restart_mode}, {14'h0, i[1:0]});
      run_cmd <= 1'b0;
      wt(0, 1'b0, 10);
    end
    // coast input while running, then a decelerating stop
    wreg(4'h0, 16'h0000);
    run_cmd <= 1'b1;
    wt(0, 1'b1, 10);
    nclk(5);
    coast_stop_input <= 1'b1;
    wt(0, 1'b0, 8);
    nclk(10);
    ck({15'h0, out_enable}, 16'h0000);
    coast_stop_input <= 1'b0;
    wt(2, 1'b1, 10);
    wt(0, 1'b1, 10);
    nclk(10);
    run_cmd <= 1'b0;
    wt(3, 1'b1, 8);
    wt(3, 1'b0, 100);
    nclk(3);
    ck({15'h0, dc_brake_on}, 16'h0000);
    // frequency command braking, level mode, release at plus 2 Hz
    wreg(4'h0, 16'h0060);
    run_cmd <= 1'b1;
    wt(0, 1'b1, 10);
    nclk(40);
    freq_cmd <= 16'h0032;
    nclk(5);
    ck({15'h0, dc_brake_on}, 16'h0000);
    wt(1, 1'b1, 60);
    freq_cmd <= 16'h012B;
    nclk(20);
    ck({15'h0, dc_brake_on}, 16'h0001);
    freq_cmd <= 16'h012C;
    wt(1, 1'b0, 8);
    run_cmd <= 1'b0;
    nclk(20);
    tally_and_finish;
  end
endmodule // tb_stop_and_dc_brake_control
